/* core/dpe_change_det.v */
`timescale 1ns/1ps
// holds the last reported image and flags a difference once
module dpe_change_det
#(
  parameter WIDTH = 24
)
(
  // clock and reset
  input wire i_ref_clk,
  input wire i_rstn,
  // sampled image
  input wire i_hold,
  input wire [WIDTH-1:0] i_data,
  // reported image
  output reg [WIDTH-1:0] o_last,
  output reg o_change
);

  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_last <= {WIDTH{1'b0}};
      o_change <= 1'b0;
    end
    else
    begin
      // freeze keeps the old image, so a change waits until release
      o_change <= 1'b0;
      if (!i_hold && (i_data != o_last))
      begin
        o_last <= i_data;
        o_change <= 1'b1;
      end
    end
  end

endmodule

/* core/dpe_defs.vh */
`ifndef DPE_DEFS_VH
`define DPE_DEFS_VH
// port width and parameter telegram layout
`define DPE_PORT_W 8
`define DPE_STD_PRM_BYTES 7
`define DPE_USER_PRM_BYTES 5
`define DPE_IDX_W 4
// user parameter byte positions within the telegram
`define DPE_IDX_FIRST 4'h7
`define DPE_IDX_MASK_C 4'h8
`define DPE_IDX_MASK_D 4'h9
`define DPE_IDX_FOURTH 4'hA
`define DPE_IDX_FIFTH 4'hB
`define DPE_IDX_LAST 4'hB
// first user parameter byte fields
`define DPE_BIT_WATCHDOG_TIMEBASE_SELECT 2
`define DPE_BIT_GROUP_MODE 3
`define DPE_FIRST_RSVD_MASK 8'hF3
// group port split
`define DPE_GRP_LO_MSB 3
`define DPE_GRP_HI_LSB 4
// reset values
`define DPE_MASK_RST 8'h00
`define DPE_BYTE_ZERO 8'h00
// register map
`define DPE_ADDR_W 4
`define DPE_REG_CTRL 4'h0
`define DPE_REG_MASK_C 4'h1
`define DPE_REG_MASK_D 4'h2
`define DPE_REG_DIAG_E 4'h3
`define DPE_REG_DIAG_C 4'h4
`define DPE_REG_DIAG_D 4'h5
`define DPE_REG_IRQ_STAT 4'h6
`define DPE_REG_IRQ_MASK 4'h7
`define DPE_REG_PRM_STAT 4'h8
// interrupt status bits
`define DPE_IRQ_W 3
`define DPE_IRQ_CHANGE 0
`define DPE_IRQ_FAULT 1
`define DPE_IRQ_PRM_ERR 2
`endif

/* core/dpe_evaluator.v */
`timescale 1ns/1ps
`include "dpe_defs.vh"
module dpe_evaluator
#(
  parameter PORT_W = `DPE_PORT_W
)
(
  // clock and reset
  input wire i_ref_clk,
  input wire i_rstn,
  // diagnostic pins, active low
  input wire [PORT_W-1:0] i_port_e_n,
  input wire [PORT_W-1:0] i_port_c_n,
  input wire [PORT_W-1:0] i_port_d_n,
  // type coding
  input wire i_ext_diag_c,
  input wire i_ext_diag_d,
  // parameter telegram byte stream
  input wire i_prm_start,
  input wire i_prm_valid,
  input wire [7:0] i_prm_byte,
  input wire i_prm_end,
  // diagnostic report hold (freeze)
  input wire i_diag_hold,
  // register port
  input wire [`DPE_ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // diagnostic report
  output wire [7:0] o_diag_e,
  output wire [7:0] o_diag_c,
  output wire [7:0] o_diag_d,
  output wire o_diag_change,
  // status outputs
  output reg o_diag_fault_output,
  output wire o_watchdog_timebase_select,
  output wire o_group_diag_mode,
  output wire o_irq
);

  // committed parameters
  reg [7:0] user_param_byte_first;
  reg [7:0] channel_port_c_mask;
  reg [7:0] channel_port_d_mask;
  reg [7:0] user_param_byte_fourth;
  reg [7:0] user_param_byte_fifth;
  // staged bytes of a telegram in progress
  reg [7:0] stg_first;
  reg [7:0] stg_mask_c;
  reg [7:0] stg_mask_d;
  reg [7:0] stg_fourth;
  reg [7:0] stg_fifth;
  reg [`DPE_IDX_W-1:0] prm_idx;
  reg prm_len_err;
  reg prm_rsvd_err;
  reg [`DPE_IRQ_W-1:0] irq_stat;
  reg [`DPE_IRQ_W-1:0] irq_mask;
  reg fault_q;
  // telegram phase, one-hot
  localparam [2:0] PRM_IDLE = 3'h1;
  localparam [2:0] PRM_RECV = 3'h2;
  localparam [2:0] PRM_OVER = 3'h4;
  reg [2:0] prm_state;
  reg [2:0] next_prm_state;

  wire [PORT_W-1:0] err_e;
  wire [PORT_W-1:0] err_c;
  wire [PORT_W-1:0] err_d;
  wire [PORT_W-1:0] rep_c;
  wire [PORT_W-1:0] rep_d;
  wire chan_err;
  wire grp_lo_err;
  wire grp_hi_err;
  wire next_fault;
  wire [3*PORT_W-1:0] last_img;
  wire prm_good;
  wire prm_bad;
  wire rsvd_bad;
  wire [`DPE_IRQ_W-1:0] irq_ev;
  wire stat_rd;
  wire prm_open;
  wire lo_qual;
  wire [3*PORT_W-1:0] img_next;

  // invert and mask per bit
  genvar g;
  generate
    for (g = 0; g < PORT_W; g = g + 1)
    begin : bit_eval
      assign err_e[g] = ~i_port_e_n[g];
      assign err_c[g] = ~i_port_c_n[g] & ~channel_port_c_mask[g] &
                        i_ext_diag_c;
      assign err_d[g] = ~i_port_d_n[g] & ~channel_port_d_mask[g] &
                        i_ext_diag_d;
      // only extended diagnosis puts channel data in the report
      assign rep_c[g] = err_c[g] & i_ext_diag_c;
      assign rep_d[g] = err_d[g] & i_ext_diag_d;
    end
  endgenerate

  assign o_group_diag_mode = user_param_byte_first[`DPE_BIT_GROUP_MODE];
  assign o_watchdog_timebase_select =
    user_param_byte_first[`DPE_BIT_WATCHDOG_TIMEBASE_SELECT];

  assign chan_err = |err_c | |err_d;
  assign grp_hi_err = |err_e[PORT_W-1:`DPE_GRP_HI_LSB];
  // one qualifier feeds both fault and report, so they disagree only while the report is held
  assign lo_qual = ~o_group_diag_mode | chan_err;
  assign grp_lo_err = |err_e[`DPE_GRP_LO_MSB:0] & lo_qual;
  // level, so the fault drops as soon as no error remains
  assign next_fault = grp_lo_err | grp_hi_err | chan_err;

  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_diag_fault_output <= 1'b0;
      fault_q <= 1'b0;
    end
    else
    begin
      o_diag_fault_output <= next_fault;
      fault_q <= o_diag_fault_output;
    end
  end

  // group mode qualifies only the report of E0-E3; C, D, E4-E7 pass
  assign img_next = {rep_d, rep_c, err_e[PORT_W-1:`DPE_GRP_HI_LSB],
                     err_e[`DPE_GRP_LO_MSB:0] &
                     {(`DPE_GRP_LO_MSB+1){lo_qual}}};

  dpe_change_det
  #(
    .WIDTH(3*PORT_W)
  )
  u_change
  (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_hold(i_diag_hold),
    .i_data(img_next),
    .o_last(last_img),
    .o_change(o_diag_change)
  );

  assign o_diag_e = last_img[PORT_W-1:0];
  assign o_diag_c = last_img[2*PORT_W-1:PORT_W];
  assign o_diag_d = last_img[3*PORT_W-1:2*PORT_W];

  // bytes count only inside a started telegram; a stray strobe after
  // reset or after an end cannot assemble parameters of its own
  always @*
  begin
    next_prm_state = prm_state;
    case (prm_state)
      PRM_IDLE:
      begin
        if (i_prm_start)
          next_prm_state = PRM_RECV;
      end
      PRM_RECV:
      begin
        if (i_prm_start)
          next_prm_state = PRM_RECV;
        else if (i_prm_end)
          next_prm_state = PRM_IDLE;
        else if (i_prm_valid && (prm_idx > `DPE_IDX_LAST))
          next_prm_state = PRM_OVER;
      end
      PRM_OVER:
      begin
        if (i_prm_start)
          next_prm_state = PRM_RECV;
        else if (i_prm_end)
          next_prm_state = PRM_IDLE;
      end
      default:
      begin
        next_prm_state = PRM_IDLE;
      end
    endcase
  end

  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      prm_state <= PRM_IDLE;
    else
      prm_state <= next_prm_state;
  end

  assign prm_open = (prm_state != PRM_IDLE);

  // parameter telegram: bytes 0-6 standard, 7-11 user
  assign prm_good = i_prm_end && (prm_state == PRM_RECV) &&
                    (prm_idx == `DPE_IDX_LAST + 4'h1) &&
                    !prm_len_err;
  assign prm_bad = i_prm_end && !prm_good;
  // reserved bits are the master's duty; we flag but still accept
  assign rsvd_bad = prm_good &&
    (((stg_first & `DPE_FIRST_RSVD_MASK) != `DPE_BYTE_ZERO) ||
     (stg_fourth != `DPE_BYTE_ZERO) ||
     (stg_fifth != `DPE_BYTE_ZERO));

  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      prm_idx <= {`DPE_IDX_W{1'b0}};
      prm_len_err <= 1'b0;
      stg_first <= `DPE_BYTE_ZERO;
      stg_mask_c <= `DPE_MASK_RST;
      stg_mask_d <= `DPE_MASK_RST;
      stg_fourth <= `DPE_BYTE_ZERO;
      stg_fifth <= `DPE_BYTE_ZERO;
    end
    else if (i_prm_start)
    begin
      prm_idx <= {`DPE_IDX_W{1'b0}};
      prm_len_err <= 1'b0;
    end
    else if (i_prm_valid && prm_open)
    begin
      if (prm_idx > `DPE_IDX_LAST)
        prm_len_err <= 1'b1;
      else
        prm_idx <= prm_idx + 4'h1;
      case (prm_idx)
        `DPE_IDX_FIRST: stg_first <= i_prm_byte;
        `DPE_IDX_MASK_C: stg_mask_c <= i_prm_byte;
        `DPE_IDX_MASK_D: stg_mask_d <= i_prm_byte;
        `DPE_IDX_FOURTH: stg_fourth <= i_prm_byte;
        `DPE_IDX_FIFTH: stg_fifth <= i_prm_byte;
        default: stg_first <= stg_first;
      endcase
    end
  end

  // commit on a good telegram, or by software write
  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      user_param_byte_first <= `DPE_BYTE_ZERO;
      channel_port_c_mask <= `DPE_MASK_RST;
      channel_port_d_mask <= `DPE_MASK_RST;
      user_param_byte_fourth <= `DPE_BYTE_ZERO;
      user_param_byte_fifth <= `DPE_BYTE_ZERO;
      prm_rsvd_err <= 1'b0;
    end
    else if (prm_good)
    begin
      user_param_byte_first <= stg_first;
      channel_port_c_mask <= stg_mask_c;
      channel_port_d_mask <= stg_mask_d;
      user_param_byte_fourth <= stg_fourth;
      user_param_byte_fifth <= stg_fifth;
      prm_rsvd_err <= rsvd_bad;
    end
    else if (i_wr)
    begin
      case (i_addr)
        `DPE_REG_CTRL: user_param_byte_first <= i_wdata;
        `DPE_REG_MASK_C: channel_port_c_mask <= i_wdata;
        `DPE_REG_MASK_D: channel_port_d_mask <= i_wdata;
        default: prm_rsvd_err <= prm_rsvd_err;
      endcase
    end
  end

  // interrupts: sticky, cleared by reading; set beats clear
  assign irq_ev[`DPE_IRQ_CHANGE] = o_diag_change;
  assign irq_ev[`DPE_IRQ_FAULT] = o_diag_fault_output & ~fault_q;
  assign irq_ev[`DPE_IRQ_PRM_ERR] = prm_bad | rsvd_bad;
  assign stat_rd = i_rd && (i_addr == `DPE_REG_IRQ_STAT);
  assign o_irq = |(irq_stat & irq_mask);

  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      irq_stat <= {`DPE_IRQ_W{1'b0}};
      irq_mask <= {`DPE_IRQ_W{1'b0}};
    end
    else
    begin
      irq_stat <= (stat_rd ? {`DPE_IRQ_W{1'b0}} : irq_stat) | irq_ev;
      if (i_wr && (i_addr == `DPE_REG_IRQ_MASK))
        irq_mask <= i_wdata[`DPE_IRQ_W-1:0];
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_rdata <= `DPE_BYTE_ZERO;
    else if (i_rd)
    begin
      case (i_addr)
        `DPE_REG_CTRL: o_rdata <= user_param_byte_first;
        `DPE_REG_MASK_C: o_rdata <= channel_port_c_mask;
        `DPE_REG_MASK_D: o_rdata <= channel_port_d_mask;
        `DPE_REG_DIAG_E: o_rdata <= o_diag_e;
        `DPE_REG_DIAG_C: o_rdata <= o_diag_c;
        `DPE_REG_DIAG_D: o_rdata <= o_diag_d;
        `DPE_REG_IRQ_STAT: o_rdata <= {5'h00, irq_stat};
        `DPE_REG_IRQ_MASK: o_rdata <= {5'h00, irq_mask};
        `DPE_REG_PRM_STAT: o_rdata <= {6'h00, prm_rsvd_err,
                                       o_diag_fault_output};
        default: o_rdata <= `DPE_BYTE_ZERO;
      endcase
    end
    else
      o_rdata <= `DPE_BYTE_ZERO;
  end

endmodule

/* sim/diagnostic_port_evaluator_tb.sv */
`timescale 1ns/1ps
`include "dpe_defs.vh"
module diagnostic_port_evaluator_tb;
  logic clk = 1'b0, rstn = 1'b0, ext_c = 1'b0, go = 1'b0, wr = 1'b0;
  logic rd = 1'b0, hold = 1'b0, ext_d = 1'b1;
  logic [7:0] pe = 8'hFF, pc = 8'hFF, pd = 8'hFF, wdata = 8'h00;
  logic [7:0] first = 8'h00, mc = 8'h00, md = 8'h00;
  logic [3:0] addr = 4'h0;
  wire st, vl, pend, busy, chg, flt, wd, gm, irq;
  wire [7:0] pb, rdata, de, dc, dd;
  int fails = 0, tests_run = 0, k;
  always #2 clk = ~clk;
  dpe_master_model u_mst (.i_ref_clk(clk), .i_rstn(rstn), .i_go(go),
    .i_first(first), .i_mask_c(mc), .i_mask_d(md),
    .i_chan_diag(ext_c | ext_d), .o_prm_start(st),
    .o_prm_valid(vl), .o_prm_byte(pb), .o_prm_end(pend), .o_busy(busy));
  dpe_evaluator DUT (.i_ref_clk(clk), .i_rstn(rstn), .i_port_e_n(pe),
    .i_port_c_n(pc), .i_port_d_n(pd), .i_ext_diag_c(ext_c),
    .i_ext_diag_d(ext_d), .i_prm_start(st), .i_prm_valid(vl),
    .i_prm_byte(pb), .i_prm_end(pend), .i_diag_hold(hold), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_diag_e(de),
    .o_diag_c(dc), .o_diag_d(dd), .o_diag_change(chg),
    .o_diag_fault_output(flt), .o_watchdog_timebase_select(wd),
    .o_group_diag_mode(gm), .o_irq(irq));
  task end_sim;
  begin
    $display("checks %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  // pins land at one edge, results are settled just after the next
  task pins(input logic [7:0] e, input logic [7:0] c, input logic [7:0] d);
  begin
    @(posedge clk);
    pe <= e;
    pc <= c;
    pd <= d;
    @(posedge clk);
    #1;
  end
  endtask
  task reg_wr(input logic [3:0] a, input logic [7:0] v);
  begin
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  end
  endtask
  task reg_rd(input logic [3:0] a, input logic [7:0] e, input string n);
  begin
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(n, e, rdata);
  end
  endtask
  task t_reset;
  begin
    cmp("fault", 8'h00, {7'h0, flt});
    cmp("timebase", 8'h00, {7'h0, wd});
    cmp("group_mode", 8'h00, {7'h0, gm});
    reg_rd(`DPE_REG_CTRL, 8'h00, "ctrl");
    reg_rd(`DPE_REG_MASK_C, 8'h00, "mask_c");
    reg_rd(`DPE_REG_MASK_D, 8'h00, "mask_d");
    reg_rd(4'hF, 8'h00, "unmapped");
    $display("test reset done");
  end
  endtask
  task t_group_off;
  begin
    pins(8'hFE, 8'hFF, 8'hFF);
    cmp("fault", 8'h01, {7'h0, flt});
    cmp("diag_e", 8'h01, de);
    cmp("change", 8'h01, {7'h0, chg});
    @(posedge clk);
    #1;
    cmp("change", 8'h00, {7'h0, chg});
    pins(8'hFF, 8'hFF, 8'hFF);
    cmp("fault", 8'h00, {7'h0, flt});
    $display("test group off done");
  end
  endtask
  task t_params;
  begin
    @(posedge clk);
    first <= 8'hFF;
    mc <= 8'h01;
    md <= 8'h00;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (k = 0; k < 40 && busy === 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    if (busy !== 1'b0)
    begin
      fails = fails + 1;
      end_sim;
    end
    cmp("timebase", 8'h01, {7'h0, wd});
    cmp("group_mode", 8'h01, {7'h0, gm});
    reg_rd(`DPE_REG_MASK_C, 8'h01, "mask_c");
    reg_rd(`DPE_REG_CTRL, 8'h0C, "ctrl");
    $display("test params done");
  end
  endtask
  task t_group_on;
  begin
    @(posedge clk);
    ext_c <= 1'b1;
    pins(8'hFE, 8'hFF, 8'hFF);
    cmp("fault", 8'h00, {7'h0, flt});
    pins(8'hFE, 8'hFE, 8'hFF);
    cmp("fault", 8'h00, {7'h0, flt});
    pins(8'hFE, 8'hFD, 8'hFF);
    cmp("fault", 8'h01, {7'h0, flt});
    cmp("diag_c", 8'h02, dc);
    pins(8'hFF, 8'hFF, 8'h7F);
    cmp("diag_d", 8'h80, dd);
    cmp("fault", 8'h01, {7'h0, flt});
    pins(8'hEF, 8'hFF, 8'hFF);
    cmp("fault", 8'h01, {7'h0, flt});
    @(posedge clk);
    ext_c <= 1'b0;
    pins(8'hFF, 8'h00, 8'hFF);
    cmp("diag_c", 8'h00, dc);
    pins(8'hFF, 8'hFF, 8'hFF);
    $display("test group on done");
  end
  endtask
  task t_hold;
  begin
    @(posedge clk);
    hold <= 1'b1;
    pins(8'hDF, 8'hFF, 8'hFF);
    cmp("change", 8'h00, {7'h0, chg});
    cmp("diag_e", 8'h00, de);
    cmp("fault", 8'h01, {7'h0, flt});
    @(posedge clk);
    hold <= 1'b0;
    @(posedge clk);
    #1;
    cmp("change", 8'h01, {7'h0, chg});
    cmp("diag_e", 8'h20, de);
    @(posedge clk);
    #1;
    cmp("change", 8'h00, {7'h0, chg});
    @(posedge clk);
    ext_d <= 1'b0;
    pins(8'hFF, 8'hFF, 8'h00);
    cmp("diag_d", 8'h00, dd);
    cmp("fault", 8'h00, {7'h0, flt});
    pins(8'hFF, 8'hFF, 8'hFF);
    @(posedge clk);
    ext_d <= 1'b1;
    $display("test hold done");
  end
  endtask
  task t_irq;
  begin
    reg_rd(`DPE_REG_IRQ_STAT, 8'h03, "irq_stat");
    reg_wr(`DPE_REG_IRQ_MASK, 8'h01);
    #1;
    cmp("irq", 8'h00, {7'h0, irq});
    pins(8'h7F, 8'hFF, 8'hFF);
    @(posedge clk);
    #1;
    cmp("irq", 8'h01, {7'h0, irq});
    reg_rd(`DPE_REG_PRM_STAT, 8'h01, "prm_stat");
    reg_rd(`DPE_REG_DIAG_E, 8'h80, "diag_e_reg");
    reg_rd(`DPE_REG_IRQ_STAT, 8'h03, "irq_stat");
    cmp("irq", 8'h00, {7'h0, irq});
    reg_wr(`DPE_REG_IRQ_MASK, 8'h00);
    pins(8'hFF, 8'hFF, 8'hFF);
    @(posedge clk);
    #1;
    cmp("irq", 8'h00, {7'h0, irq});
    $display("test irq done");
  end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_group_off;
    t_params;
    t_group_on;
    t_hold;
    t_irq;
    end_sim;
  end
endmodule

/* sim/dpe_checker.sv */
`timescale 1ns/1ps
module dpe_checker
(
  // clock and reset
  input wire i_ref_clk,
  input wire i_rstn,
  // pins and controls
  input wire [7:0] i_port_e_n,
  input wire [7:0] i_port_c_n,
  input wire [7:0] i_port_d_n,
  input wire i_ext_diag_c,
  input wire i_ext_diag_d,
  input wire i_prm_end,
  input wire i_diag_hold,
  input wire i_wr,
  // results
  input wire [7:0] o_diag_e,
  input wire [7:0] o_diag_c,
  input wire o_diag_change,
  input wire o_diag_fault_output,
  input wire o_watchdog_timebase_select,
  input wire o_group_diag_mode
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // mask or mode updates land one edge late, so skip those cycles
  sequence s_quiet;
    $stable(i_port_e_n) && $stable(i_port_c_n) && $stable(i_port_d_n)
      && $stable(i_ext_diag_c) && $stable(i_ext_diag_d)
      && !i_diag_hold && !$past(i_diag_hold)
      && !$past(i_wr) && !$past(i_prm_end);
  endsequence
  chk_e_high_fault: assert property (!(&i_port_e_n[7:4])
    |=> o_diag_fault_output) else $error("high group error lost");
  chk_group_off: assert property ((!o_group_diag_mode
    && !(&i_port_e_n)) |=> o_diag_fault_output) else $error("no fault");
  chk_fault_clear: assert property (((&i_port_e_n)
    && (&i_port_c_n) && (&i_port_d_n)) |=> !o_diag_fault_output)
    else $error("fault without error");
  chk_group_qual: assert property ((o_group_diag_mode
    && (&i_port_e_n[7:4]) && (&i_port_c_n) && (&i_port_d_n))
    |=> !o_diag_fault_output) else $error("unqualified low fault");
  chk_change_once: assert property (s_quiet
    |=> !o_diag_change) else $error("change reported twice");
  chk_ext_off: assert property ((!i_ext_diag_c && !i_diag_hold)
    |=> (o_diag_c == 8'h00)) else $error("port c image not zero");
  chk_image_hi: assert property (!i_diag_hold
    |=> (((o_diag_e ^ $past(i_port_e_n)) & 8'hF0) == 8'hF0))
    else $error("high group image wrong");
  chk_param_src: assert property (($changed(o_group_diag_mode)
    || $changed(o_watchdog_timebase_select))
    |-> ($past(i_prm_end) || $past(i_wr))) else $error("param moved");
endmodule
bind dpe_evaluator dpe_checker u_chk (.*);

/* sim/dpe_master_model.sv */
`timescale 1ns/1ps
module dpe_master_model
(
  // clock and reset
  input wire i_ref_clk,
  input wire i_rstn,
  // request
  input wire i_go,
  input wire [7:0] i_first,
  input wire [7:0] i_mask_c,
  input wire [7:0] i_mask_d,
  input wire i_chan_diag,
  // telegram stream
  output wire o_prm_start,
  output wire o_prm_valid,
  output wire [7:0] o_prm_byte,
  output wire o_prm_end,
  output wire o_busy
);
  reg [3:0] cnt;
  reg [7:0] val;
  wire [3:0] idx;
  assign idx = cnt - 4'h2;
  assign o_busy = (cnt != 4'h0);
  assign o_prm_start = (cnt == 4'h1);
  assign o_prm_valid = (cnt >= 4'h2) && (cnt <= 4'hD);
  assign o_prm_end = (cnt == 4'hE);
  // idle byte lane shows the count and its inverse (0x0F when not busy) so a stale value never looks valid
  assign o_prm_byte = o_prm_valid ? val : {cnt, ~cnt};
  always @*
  begin
    case (idx)
      // without channel diagnosis: group mode and masks go out as zero
      4'h7: val = i_first & (i_chan_diag ? 8'h0C : 8'h04);
      4'h8: val = i_chan_diag ? i_mask_c : 8'h00;
      4'h9: val = i_chan_diag ? i_mask_d : 8'h00;
      default: val = 8'h00;
    endcase
  end
  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      cnt <= 4'h0;
    else if (cnt == 4'hE)
      cnt <= 4'h0;
    else if (cnt != 4'h0 || i_go)
      cnt <= cnt + 4'h1;
  end
endmodule
